//--- logic/ces_pin_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes every input bit is asynchronous to clk.
`timescale 1ns/100ps
module ces_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] stable
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] next_stable;

   initial begin
      if (WIDTH < 1) begin
         $error("ces_pin_sync needs WIDTH of at least one");
      end
   end

   // Stage one feeds only stage two, so no gate sees a metastable level.
   always_comb begin
      agree = ~(stage2 ^ stage3);
      next_stable = (agree & stage3) | (~agree & stable);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         stable <= '0;
      end else begin
         stage1 <= raw;
         stage2 <= stage1;
         stage3 <= stage2;
         stable <= next_stable;
      end
   end

endmodule : ces_pin_sync

//--- logic/ces_pkg.sv
// Shared constants and types for the charger enable sequencer.
// Assumes a single 10 MHz clock domain and a 32-bit APB register bus.
package ces_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int APB_ADDR_WIDTH = 8;
   localparam int APB_DATA_WIDTH = 32;
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_INT_STATUS = 8'h08;
   localparam logic [7:0] OFF_INT_MASK = 8'h0C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_REGULATOR_ENABLE = 0;
   localparam int CTRL_SETUP_DONE = 1;
   localparam int CTRL_WIDTH = 2;

   localparam int STAT_ACTIVE = 0;
   localparam int STAT_REGULATOR_ON = 1;
   localparam int STAT_CONVERTER_RUN = 2;
   localparam int STAT_DATA_SWITCH = 3;
   localparam int STAT_OVERVOLTAGE = 4;
   localparam int STAT_REGISTER_VARIANT = 5;
   localparam int STAT_RUN_PERMIT = 6;

   localparam int INT_UNCONFIGURED = 0;
   localparam int INT_OVERVOLTAGE = 1;
   localparam int INT_BIAS_UNDERVOLTAGE = 2;
   localparam int INT_WIDTH = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [CTRL_WIDTH-1:0] CONTROL_RESET = 2'h0;
   localparam logic [INT_WIDTH-1:0] INT_STATUS_RESET = 3'h0;
   localparam logic [INT_WIDTH-1:0] INT_MASK_RESET = 3'h1;

   // ----------------------------------------------------------------
   // Synchroniser and strap timing
   // ----------------------------------------------------------------
   localparam int SYNC_INPUTS = 7;
   localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h6;

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CES_STANDBY = 3'b001,
      CES_REG_START = 3'b010,
      CES_ACTIVE = 3'b100
   } ces_state_type;

endpackage : ces_pkg

//--- logic/ces_top.sv
// Enable and power-up sequencing for a step-down converter with a USB port front end.
// Assumes pins are asynchronous, the register bus is APB on clk, reset is async high.
//
// Operation
// - System enable low puts the device into low-current standby.
// - After every system reset the register variant raises its alert.
// - Register variant keeps the converter off until software sets the setup-done flag.
// - Run permit is the AND of enable pin and enable bit.
// - Pin-configured variant treats the enable bit as always high.
// - Enable pin low overrides a written enable bit.
// - Transceiver supply overvoltage turns the USB data switches off.
// - Regulator starts with enable high and supply good, stops with enable low.
// - Internal logic stays disabled while the regulator output is low.
// - Enable pin low at system enable keeps converter off until pin rises.
// - Shared pin is interrupt in register variant, attach in pin variant.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
module ces_top #(
   parameter int ADDR_WIDTH = ces_pkg::APB_ADDR_WIDTH
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [ces_pkg::APB_DATA_WIDTH-1:0] pwdata,
   output logic pready,
   output logic [ces_pkg::APB_DATA_WIDTH-1:0] prdata,
   output logic pslverr,
   input wire logic system_enable_input,
   input wire logic converter_enable_pin,
   input wire logic switch_supply_rail_ok,
   input wire logic bias_rail_ok,
   input wire logic transceiver_overvoltage,
   input wire logic attach_detect,
   input wire logic register_variant_strap,
   output logic standby,
   output logic regulator_power_up,
   output logic logic_enable,
   output logic converter_switch_enable,
   output logic data_switch_enable,
   output logic alert_out,
   output logic alert_oe_n,
   output logic irq
);
   import ces_pkg::*;

   initial begin
      if (ADDR_WIDTH < APB_ADDR_WIDTH || ADDR_WIDTH > 32) begin
         $error("ces_top needs ADDR_WIDTH between 8 and 32");
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Only the low byte is decoded, so the map repeats through wider spaces.
   function automatic logic [3:0] decode(input logic [7:0] addr);
      logic [3:0] hit;
      hit = 4'h0;
      case (addr)
         OFF_CONTROL: hit = 4'h1;
         OFF_STATUS: hit = 4'h2;
         OFF_INT_STATUS: hit = 4'h4;
         OFF_INT_MASK: hit = 4'h8;
         default: hit = 4'h0;
      endcase
      return hit;
   endfunction : decode

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [SYNC_INPUTS-1:0] pins_raw;
   logic [SYNC_INPUTS-1:0] pins;
   logic sys_en;
   logic conv_pin;
   logic supply_ok;
   logic bias_ok;
   logic ovlo;
   logic attach;
   logic strap;

   assign pins_raw = {register_variant_strap, attach_detect, transceiver_overvoltage,
                      bias_rail_ok, switch_supply_rail_ok, converter_enable_pin,
                      system_enable_input};
   assign sys_en = pins[0];
   assign conv_pin = pins[1];
   assign supply_ok = pins[2];
   assign bias_ok = pins[3];
   assign ovlo = pins[4];
   assign attach = pins[5];
   assign strap = pins[6];

   ces_pin_sync #(
      .WIDTH(SYNC_INPUTS)
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .raw(pins_raw),
      .stable(pins)
   );

   // ----------------------------------------------------------------
   // Variant strap capture
   // ----------------------------------------------------------------
   // The strap is read once the synchroniser has had time to settle, then frozen.
   // The window outlasts the four-edge synchroniser latency, so the last sample is the real strap.
   logic [2:0] strap_count;
   logic [2:0] next_strap_count;
   logic register_variant;
   logic next_register_variant;

   always_comb begin
      next_strap_count = strap_count;
      next_register_variant = register_variant;
      if (strap_count != STRAP_SETTLE_CYCLES) begin
         next_strap_count = strap_count + 3'h1;
         next_register_variant = strap;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         strap_count <= 3'h0;
         register_variant <= 1'b0;
      end else begin
         strap_count <= next_strap_count;
         register_variant <= next_register_variant;
      end
   end

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   ces_state_type state;
   ces_state_type next_state;
   logic entering_active;

   always_comb begin
      next_state = state;
      case (state)
         CES_STANDBY: begin
            if (sys_en && supply_ok) begin
               next_state = CES_REG_START;
            end
         end
         CES_REG_START: begin
            if (!sys_en) begin
               next_state = CES_STANDBY;
            end else if (bias_ok) begin
               next_state = CES_ACTIVE;
            end
         end
         CES_ACTIVE: begin
            if (!sys_en) begin
               next_state = CES_STANDBY;
            end else if (!bias_ok) begin
               next_state = CES_REG_START;
            end
         end
         default: begin
            next_state = CES_STANDBY;
         end
      endcase
      entering_active = (next_state == CES_ACTIVE) && (state != CES_ACTIVE);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= CES_STANDBY;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // One wait state gives registered read data and response flags.
   logic [3:0] hit;
   logic access_wait;
   logic write_done;
   logic next_pready;
   logic next_pslverr;
   logic [APB_DATA_WIDTH-1:0] next_prdata;
   logic [CTRL_WIDTH-1:0] control;
   logic [CTRL_WIDTH-1:0] next_control;
   logic [INT_WIDTH-1:0] int_status;
   logic [INT_WIDTH-1:0] next_int_status;
   logic [INT_WIDTH-1:0] int_mask;
   logic [INT_WIDTH-1:0] next_int_mask;
   logic [INT_WIDTH-1:0] int_set;
   logic [INT_WIDTH-1:0] int_clear;
   logic [6:0] status_word;
   logic ovlo_seen;
   logic next_ovlo_seen;
   logic active;

   assign active = (state == CES_ACTIVE);

   always_comb begin
      hit = decode(paddr[7:0]);
      access_wait = psel && penable && !pready;
      write_done = psel && penable && pready && pwrite && !pslverr;
      next_pready = access_wait;
      next_pslverr = access_wait && (hit == 4'h0);
      next_prdata = '0;
      if (access_wait && !pwrite) begin
         if (hit[0]) begin
            next_prdata[CTRL_WIDTH-1:0] = control;
         end
         if (hit[1]) begin
            next_prdata[6:0] = status_word;
         end
         if (hit[2]) begin
            next_prdata[INT_WIDTH-1:0] = int_status;
         end
         if (hit[3]) begin
            next_prdata[INT_WIDTH-1:0] = int_mask;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control, interrupt status and mask
   // ----------------------------------------------------------------
   always_comb begin
      next_control = control;
      next_int_mask = int_mask;
      int_clear = '0;
      if (write_done && hit[0]) begin
         next_control = pwdata[CTRL_WIDTH-1:0];
      end
      if (write_done && hit[3]) begin
         next_int_mask = pwdata[INT_WIDTH-1:0];
      end
      if (write_done && hit[2]) begin
         int_clear = pwdata[INT_WIDTH-1:0];
      end
      // Control state is lost whenever the logic is out of its active state.
      if (!active) begin
         next_control = CONTROL_RESET;
      end
      next_ovlo_seen = ovlo;
      int_set = '0;
      int_set[INT_UNCONFIGURED] = entering_active;
      int_set[INT_OVERVOLTAGE] = active && ovlo && !ovlo_seen;
      int_set[INT_BIAS_UNDERVOLTAGE] = active && !bias_ok;
      // A set in the same cycle as a clear wins, so no event is dropped.
      next_int_status = (int_status & ~int_clear) | int_set;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
         control <= CONTROL_RESET;
         int_status <= INT_STATUS_RESET;
         int_mask <= INT_MASK_RESET;
         ovlo_seen <= 1'b0;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
         control <= next_control;
         int_status <= next_int_status;
         int_mask <= next_int_mask;
         ovlo_seen <= next_ovlo_seen;
      end
   end

   // ----------------------------------------------------------------
   // Converter permit and pin outputs
   // ----------------------------------------------------------------
   logic run_permit;
   logic configured;
   logic irq_level;
   logic alert_assert;
   logic next_standby;
   logic next_regulator_power_up;
   logic next_logic_enable;
   logic next_converter_switch_enable;
   logic next_data_switch_enable;
   logic next_alert_oe_n;
   logic next_irq;

   always_comb begin
      // An enable pin held low at start simply keeps the AND false.
      run_permit = conv_pin && (register_variant ? control[CTRL_REGULATOR_ENABLE] : 1'b1);
      configured = register_variant ? control[CTRL_SETUP_DONE] : 1'b1;
      irq_level = |(int_status & int_mask);
      alert_assert = register_variant ? irq_level : attach;
      next_standby = (next_state == CES_STANDBY);
      next_regulator_power_up = (next_state != CES_STANDBY);
      next_logic_enable = (next_state == CES_ACTIVE);
      next_converter_switch_enable = active && sys_en && bias_ok && configured && run_permit;
      next_data_switch_enable = active && !ovlo;
      next_alert_oe_n = !alert_assert;
      next_irq = irq_level;
      status_word = '0;
      status_word[STAT_ACTIVE] = active;
      status_word[STAT_REGULATOR_ON] = regulator_power_up;
      status_word[STAT_CONVERTER_RUN] = converter_switch_enable;
      status_word[STAT_DATA_SWITCH] = data_switch_enable;
      status_word[STAT_OVERVOLTAGE] = ovlo;
      status_word[STAT_REGISTER_VARIANT] = register_variant;
      status_word[STAT_RUN_PERMIT] = run_permit;
   end

   // The shared pin is open drain: it only ever pulls low.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         standby <= 1'b1;
         regulator_power_up <= 1'b0;
         logic_enable <= 1'b0;
         converter_switch_enable <= 1'b0;
         data_switch_enable <= 1'b0;
         alert_out <= 1'b0;
         alert_oe_n <= 1'b1;
         irq <= 1'b0;
      end else begin
         standby <= next_standby;
         regulator_power_up <= next_regulator_power_up;
         logic_enable <= next_logic_enable;
         converter_switch_enable <= next_converter_switch_enable;
         data_switch_enable <= next_data_switch_enable;
         alert_out <= 1'b0;
         alert_oe_n <= next_alert_oe_n;
         irq <= next_irq;
      end
   end

endmodule : ces_top

//--- tb/ces_bias_model.sv
// Behavioural model of the internal regulator output seen by the sequencer.
// Assumes regulator_power_up comes from the design and brown_out from the bench.
`timescale 1ns/100ps
module ces_bias_model #(
   parameter int RAMP = 4
) (
   input wire logic clk,
   input wire logic regulator_power_up,
   input wire logic brown_out,
   output logic bias_rail_ok
);
   int ramp_cnt = 0;
   initial bias_rail_ok = 1'b0;
   // The output only reports good after a ramp, so the lockout path is exercised.
   always @(posedge clk) begin
      if (!regulator_power_up || brown_out) begin
         ramp_cnt <= 0;
         bias_rail_ok <= 1'b0;
      end else if (ramp_cnt < RAMP) begin
         ramp_cnt <= ramp_cnt + 1;
      end else begin
         bias_rail_ok <= 1'b1;
      end
   end
endmodule : ces_bias_model

//--- tb/ces_top_assertions.sv
// Concurrent checks on the ports of the charger enable sequencer.
// Assumes it is bound into ces_top and that the strap input is held constant.
`timescale 1ns/100ps
module ces_top_assertions #(
   parameter int ADDR_WIDTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [ces_pkg::APB_DATA_WIDTH-1:0] pwdata,
   input wire logic pready,
   input wire logic system_enable_input,
   input wire logic converter_enable_pin,
   input wire logic switch_supply_rail_ok,
   input wire logic bias_rail_ok,
   input wire logic transceiver_overvoltage,
   input wire logic attach_detect,
   input wire logic register_variant_strap,
   input wire logic standby,
   input wire logic regulator_power_up,
   input wire logic logic_enable,
   input wire logic converter_switch_enable,
   input wire logic data_switch_enable,
   input wire logic alert_oe_n,
   input wire logic irq
);
   import ces_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ----------------------------------------------------------------
   // Shadow of the setup flags, cleared whenever the device leaves active.
   // ----------------------------------------------------------------
   logic cfg;
   logic next_cfg;
   always_comb begin
      next_cfg = cfg;
      if (!logic_enable) begin
         next_cfg = 1'b0;
      end else if (psel && penable && pready && pwrite && paddr[7:0] == OFF_CONTROL) begin
         next_cfg = pwdata[CTRL_SETUP_DONE] && pwdata[CTRL_REGULATOR_ENABLE];
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg <= 1'b0;
      end else begin
         cfg <= next_cfg;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_STANDBY: assert property (!system_enable_input [*8] |-> standby && !regulator_power_up)
      else $error("standby not entered with system enable low");
   AST_REG_UP: assert property ((system_enable_input && switch_supply_rail_ok) [*8] |-> regulator_power_up)
      else $error("regulator not started");
   AST_STBY_OFF: assert property (standby [*2] |-> !converter_switch_enable)
      else $error("converter runs in standby");
   AST_LOCKOUT: assert property (!bias_rail_ok [*8] |-> !logic_enable && !converter_switch_enable)
      else $error("logic enabled under bias lockout");
   AST_PIN_OFF: assert property (!converter_enable_pin [*8] |-> !converter_switch_enable)
      else $error("converter runs with enable pin low");
   AST_CSE_CAUSE: assert property (converter_switch_enable |-> $past(logic_enable) && ($past(cfg) || !register_variant_strap))
      else $error("converter runs before setup");
   AST_OVLO: assert property (transceiver_overvoltage [*8] |-> !data_switch_enable)
      else $error("data switches on during overvoltage");
   AST_INT_PIN: assert property (register_variant_strap |-> alert_oe_n == !irq)
      else $error("shared pin does not follow interrupt");
   AST_ATTACH: assert property (!register_variant_strap && attach_detect [*8] |-> !alert_oe_n)
      else $error("shared pin does not show attach");
   COV_RUN: cover property (converter_switch_enable);
   COV_ALERT: cover property ($fell(alert_oe_n));
   COV_OVLO: cover property ($fell(data_switch_enable));
endmodule : ces_top_assertions

//--- tb/tb_top.sv
// Self-checking bench for the charger enable sequencer.
// Assumes the design answers APB with one wait state and pins settle within 8 cycles.
`timescale 1ns/100ps
module tb_top;
   import ces_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic system_enable_input = 1'b0;
   logic converter_enable_pin = 1'b0;
   logic switch_supply_rail_ok = 1'b1;
   logic bias_rail_ok;
   logic transceiver_overvoltage = 1'b0;
   logic attach_detect = 1'b0;
   logic register_variant_strap = 1'b1;
   logic brown_out = 1'b0;
   logic standby, regulator_power_up, logic_enable, converter_switch_enable;
   logic data_switch_enable, alert_out, alert_oe_n, irq;
   int n_mismatch = 0;
   int n_tests = 0;
   always #50 clk = ~clk;
   ces_top #(.ADDR_WIDTH(8)) DUT (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .system_enable_input, .converter_enable_pin,
      .switch_supply_rail_ok, .bias_rail_ok, .transceiver_overvoltage, .attach_detect,
      .register_variant_strap, .standby, .regulator_power_up, .logic_enable,
      .converter_switch_enable, .data_switch_enable, .alert_out, .alert_oe_n, .irq);
   ces_bias_model #(.RAMP(4)) u_bias (.clk, .regulator_power_up, .brown_out, .bias_rail_ok);
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask : settle
   task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         n_mismatch++;
         final_report();
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      settle(3);
   endtask : wr
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r, exp);
   endtask : rd_chk
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_idle();
      logic [31:0] r;
      logic e;
      check("standby", standby, 1);
      check("reg_up", regulator_power_up, 0);
      rd_chk("control", OFF_CONTROL, 0);
      rd_chk("int_mask", OFF_INT_MASK, 32'h1);
      rd_chk("int_status", OFF_INT_STATUS, 0);
      apb(1'b0, 8'h10, 32'h0, r, e);
      check("slverr", e, 1);
   endtask : t_idle
   task automatic t_powerup();
      system_enable_input <= 1'b1;
      settle(25);
      check("standby", standby, 0);
      check("reg_up", regulator_power_up, 1);
      check("active", logic_enable, 1);
      check("irq", irq, 1);
      check("alert", alert_oe_n, 0);
      check("alert_pull", alert_out, 0);
      check("conv", converter_switch_enable, 0);
      check("dsw", data_switch_enable, 1);
      rd_chk("int_status", OFF_INT_STATUS, 32'h1);
   endtask : t_powerup
   task automatic t_enable();
      wr(OFF_CONTROL, 32'h1);
      check("conv_nosetup", converter_switch_enable, 0);
      wr(OFF_CONTROL, 32'h3);
      check("conv_pinlow", converter_switch_enable, 0);
      converter_enable_pin <= 1'b1;
      settle(8);
      check("conv_on", converter_switch_enable, 1);
      rd_chk("status", OFF_STATUS, 32'h6F);
      wr(OFF_CONTROL, 32'h2);
      check("conv_bitlow", converter_switch_enable, 0);
      wr(OFF_CONTROL, 32'h3);
      converter_enable_pin <= 1'b0;
      settle(8);
      check("conv_override", converter_switch_enable, 0);
      converter_enable_pin <= 1'b1;
      settle(8);
      check("conv_again", converter_switch_enable, 1);
      wr(OFF_INT_STATUS, 32'h1);
      check("irq_clr", irq, 0);
      check("alert_clr", alert_oe_n, 1);
   endtask : t_enable
   task automatic t_ovlo();
      transceiver_overvoltage <= 1'b1;
      settle(8);
      check("dsw_off", data_switch_enable, 0);
      rd_chk("int_ov", OFF_INT_STATUS, 32'h2);
      check("irq_masked", irq, 0);
      wr(OFF_INT_MASK, 32'h3);
      check("irq_unmasked", irq, 1);
      transceiver_overvoltage <= 1'b0;
      settle(8);
      check("dsw_on", data_switch_enable, 1);
      wr(OFF_INT_STATUS, 32'h2);
      check("irq_cleared", irq, 0);
   endtask : t_ovlo
   task automatic t_bias_uv();
      brown_out <= 1'b1;
      settle(10);
      check("active_uv", logic_enable, 0);
      check("conv_uv", converter_switch_enable, 0);
      rd_chk("control_uv", OFF_CONTROL, 0);
      brown_out <= 1'b0;
      settle(20);
      check("active_back", logic_enable, 1);
      rd_chk("int_uv", OFF_INT_STATUS, 32'h5);
      check("irq_uv", irq, 1);
      check("conv_unset", converter_switch_enable, 0);
   endtask : t_bias_uv
   task automatic t_standby();
      system_enable_input <= 1'b0;
      settle(10);
      check("standby_back", standby, 1);
      check("reg_down", regulator_power_up, 0);
      check("active_down", logic_enable, 0);
      switch_supply_rail_ok <= 1'b0;
      system_enable_input <= 1'b1;
      settle(10);
      check("reg_nosupply", regulator_power_up, 0);
      check("standby_nosupply", standby, 1);
      system_enable_input <= 1'b0;
      switch_supply_rail_ok <= 1'b1;
      settle(8);
   endtask : t_standby
   task automatic t_pin_variant();
      reset <= 1'b1;
      register_variant_strap <= 1'b0;
      settle(4);
      reset <= 1'b0;
      settle(8);
      system_enable_input <= 1'b1;
      settle(25);
      check("pin_conv", converter_switch_enable, 1);
      check("pin_noattach", alert_oe_n, 1);
      attach_detect <= 1'b1;
      settle(8);
      check("pin_attach", alert_oe_n, 0);
      converter_enable_pin <= 1'b0;
      settle(8);
      check("pin_conv_off", converter_switch_enable, 0);
   endtask : t_pin_variant
   initial begin
      settle(4);
      reset <= 1'b0;
      t_idle();
      t_powerup();
      t_enable();
      t_ovlo();
      t_bias_uv();
      t_standby();
      t_pin_variant();
      final_report();
   end
endmodule : tb_top
bind ces_top ces_top_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.clk, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .system_enable_input, .converter_enable_pin,
   .switch_supply_rail_ok, .bias_rail_ok, .transceiver_overvoltage, .attach_detect,
   .register_variant_strap, .standby, .regulator_power_up, .logic_enable,
   .converter_switch_enable, .data_switch_enable, .alert_oe_n, .irq);
